// ===== core/vsb_sync_map.vh
// How it works
// - Four-symbol correlator searches sync while free-running.
// - Clock loop steers only from sampled segment sync.
// - Segment confidence counter gates the later loops.
// - Overload lowers IF gain first, RF later.
// - Coherent gain integrates sync amplitude against reference.
// - Field sync uses the selected data path, comb or raw.
// - Symbol-wise compare against both field references.
// - Field confidence counter qualifies the field sync.
// - Middle PN63 polarity picks field one or two.
// - Comb subtracts sample delayed twelve symbols.
// - Twelve-symbol delay puts nulls at rate/12.
// - Comb path carries fifteen levels, flagged downstream.
// - Raw-path noise is sample minus stored reference.
// - Comb-path noise uses the combed stored reference.
// - Both noise terms squared, summed over field syncs.
// - Confident mux picks the lower-noise path.
`ifndef VSB_SYNC_MAP_VH
`define VSB_SYNC_MAP_VH

// ----------------------------------------
// Segment and field sync timing, in symbols; field length in segments
// ----------------------------------------
`define SEG_LEN_M1 10'h33F
`define SYNC_LAST 10'h003
`define PN511_START 10'h004
`define PN63_A_START 10'h203
`define PN63_MID_START 10'h242
`define PN63_C_START 10'h281
`define CORR_END 10'h2C0
`define COMB_DELAY 10'h00C
`define FIELD_SEGS_M1 9'h138

// ----------------------------------------
// Levels and gain constants
// ----------------------------------------
`define ADC_CLIP 10'h1F0
`define REF_LEVEL 10'h050
`define SYNC_AMP_REF 12'h050
`define GAIN_STEP 16'h0080
`define GAIN_RESET 16'hFFFF
`define SYNC_PATTERN 4'h9

`endif

// ===== core/sync_confidence.v
`timescale 1ns/1ps
`default_nettype none

module sync_confidence #(
	parameter W = 4,
	parameter [W-1:0] THRESH = 8
) (
	input wire core_clk, // Block clock.
	input wire rst_ok_n, // Synchronised reset, active low.
	input wire clear, // Drops count and lock.
	input wire tick, // One evaluation this cycle.
	input wire hit, // Sync seen where expected.
	output reg [W-1:0] count, // Present confidence.
	output reg locked // Lock flag.
);

	// ----------------------------------------
	// Saturating up/down counter with lock hysteresis
	// ----------------------------------------
	// Lock is taken at the threshold and dropped only at zero, so a few
	// noisy misses do not chatter the dependent loops.
	always @(posedge core_clk or negedge rst_ok_n) begin
		if (!rst_ok_n) begin
			count <= {W{1'b0}};
			locked <= 1'b0;
		end else if (clear) begin
			count <= {W{1'b0}};
			locked <= 1'b0;
		end else if (tick) begin
			if (hit && count != THRESH) begin
				count <= count + {{(W-1){1'b0}}, 1'b1};
				if (count == THRESH - {{(W-1){1'b0}}, 1'b1})
					locked <= 1'b1;
			end else if (!hit && count != {W{1'b0}}) begin
				count <= count - {{(W-1){1'b0}}, 1'b1};
				if (count == {{(W-1){1'b0}}, 1'b1})
					locked <= 1'b0;
			end
		end
	end

endmodule // sync_confidence

`default_nettype wire

// ===== core/vsb_sync_front.v
`timescale 1ns/1ps
`default_nettype none
`include "vsb_sync_map.vh"

module vsb_sync_front #(
	parameter [11:0] SEG_THR = 12'h100,
	parameter [21:0] FS_THR = 22'h004000,
	parameter SEG_CONF_W = 4,
	parameter [SEG_CONF_W-1:0] SEG_CONF_THR = 8,
	parameter FS_CONF_W = 3,
	parameter [FS_CONF_W-1:0] FS_CONF_THR = 3,
	parameter PATH_CONF_W = 3,
	parameter [PATH_CONF_W-1:0] PATH_CONF_THR = 4,
	parameter [1:0] FS_AVG_M1 = 2'h3,
	parameter [8:0] PN511_SEED = 9'h1FF,
	parameter [8:0] PN511_TAPS = 9'h110,
	parameter [5:0] PN63_SEED = 6'h3F,
	parameter [5:0] PN63_TAPS = 6'h21
) (
	input wire core_clk, // 40 MHz block clock.
	input wire rst_n, // Asynchronous reset, active low.
	input wire [9:0] sample_in, // Signed converter sample.
	input wire sample_valid, // One pulse per recovered symbol.
	output reg [10:0] data_out, // Selected path sample, signed.
	output reg data_valid, // Pulse with data_out.
	output reg comb_sel, // Comb path in use, fifteen levels.
	output reg seg_start, // Pulse on first sync symbol.
	output reg seg_lock, // Segment sync confident.
	output reg field_sync, // Pulse at end of field sync.
	output reg field_id, // 0 first field, 1 second field.
	output reg field_lock, // Field sync confident.
	output reg [7:0] if_gain, // IF gain control word.
	output reg [7:0] rf_gain, // RF gain control word.
	output reg [15:0] clk_ctrl // Symbol clock oscillator steering.
);

	// ----------------------------------------
	// Reset release
	// ----------------------------------------
	// Assert at once, release on the clock so no flop sees a runt edge.
	reg rst_s1_q;
	reg rst_ok_n;
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_s1_q <= 1'b0;
			rst_ok_n <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_ok_n <= rst_s1_q;
		end
	end

	// ----------------------------------------
	// Segment position and four-symbol correlator
	// ----------------------------------------
	reg [9:0] pos_q;
	reg [9:0] sh_a_q;
	reg [9:0] sh_b_q;
	reg [9:0] sh_c_q;
	wire [11:0] sa = {{2{sh_a_q[9]}}, sh_a_q};
	wire [11:0] sb = {{2{sh_b_q[9]}}, sh_b_q};
	wire [11:0] sc = {{2{sh_c_q[9]}}, sh_c_q};
	wire [11:0] sx = {{2{sample_in[9]}}, sample_in};
	// Pattern +,-,-,+ oldest first.
	wire signed [11:0] seg_corr = sa - sb - sc + sx;
	wire corr_big = ($signed(seg_corr) > $signed(SEG_THR));
	wire at_sync = (pos_q == `SYNC_LAST);
	wire seg_hit = sample_valid && at_sync && corr_big;
	wire [SEG_CONF_W-1:0] seg_count;
	wire seg_locked;
	// While nothing is trusted, any strong correlation realigns the count.
	wire realign = sample_valid && corr_big && !at_sync && (seg_count == {SEG_CONF_W{1'b0}});

	always @(posedge core_clk or negedge rst_ok_n) begin
		if (!rst_ok_n) begin
			pos_q <= 10'h000;
			sh_a_q <= 10'h000;
			sh_b_q <= 10'h000;
			sh_c_q <= 10'h000;
		end else if (sample_valid) begin
			sh_a_q <= sh_b_q;
			sh_b_q <= sh_c_q;
			sh_c_q <= sample_in;
			if (realign)
				pos_q <= `PN511_START;
			else if (pos_q == `SEG_LEN_M1)
				pos_q <= 10'h000;
			else
				pos_q <= pos_q + 10'h001;
		end
	end

	sync_confidence #(.W(SEG_CONF_W), .THRESH(SEG_CONF_THR)) u_seg_conf (
		.core_clk(core_clk),
		.rst_ok_n(rst_ok_n),
		.clear(1'b0),
		.tick(sample_valid && at_sync),
		.hit(corr_big),
		.count(seg_count),
		.locked(seg_locked)
	);

	// ----------------------------------------
	// Symbol clock loop steering
	// ----------------------------------------
	// The middle two sync symbols are equal when the clock is phased, so
	// their difference is the timing error. Only taken on a sync hit, so
	// random data never moves the oscillator.
	reg signed [15:0] freq_q;
	wire signed [15:0] tim_err = {{4{sb[11]}}, sb} - {{4{sc[11]}}, sc};
	always @(posedge core_clk or negedge rst_ok_n) begin
		if (!rst_ok_n) begin
			freq_q <= 16'sh0000;
			clk_ctrl <= 16'h0000;
		end else if (seg_hit) begin
			freq_q <= freq_q + tim_err;
			clk_ctrl <= freq_q + (tim_err <<< 2);
		end
	end

	// ----------------------------------------
	// Gain control
	// ----------------------------------------
	// One total gain integrator; its upper part maps to IF, lower to RF,
	// so a falling total gain takes IF down first and RF only afterwards.
	reg [15:0] integ_q;
	reg ov_seen_q;
	wire [9:0] mag = sample_in[9] ? (10'h000 - sample_in) : sample_in;
	wire overload = sample_valid && (mag >= `ADC_CLIP);
	wire signed [11:0] sync_amp = seg_corr >>> 2;
	wire signed [17:0] amp_err = {6'h00, `SYNC_AMP_REF} - {{6{sync_amp[11]}}, sync_amp};
	wire signed [17:0] integ_sum = {2'h0, integ_q} + amp_err;
	wire [8:0] total_gain = integ_q[15:7];

	always @(posedge core_clk or negedge rst_ok_n) begin
		if (!rst_ok_n) begin
			integ_q <= `GAIN_RESET;
			ov_seen_q <= 1'b0;
		end else if (!seg_locked) begin
			if (overload) begin
				integ_q <= (integ_q > `GAIN_STEP) ? integ_q - `GAIN_STEP : 16'h0000;
				ov_seen_q <= 1'b1;
			end else if (sample_valid && pos_q == `SEG_LEN_M1) begin
				if (!ov_seen_q)
					integ_q <= (integ_q < (`GAIN_RESET - `GAIN_STEP)) ? integ_q + `GAIN_STEP : `GAIN_RESET;
				ov_seen_q <= 1'b0;
			end
		end else if (seg_hit) begin
			ov_seen_q <= 1'b0;
			if (integ_sum < 18'sh00000)
				integ_q <= 16'h0000;
			else if (integ_sum > 18'sh0FFFF)
				integ_q <= 16'hFFFF;
			else
				integ_q <= integ_sum[15:0];
		end
	end

	// RF sits at full gain until IF has been used up.
	always @(posedge core_clk or negedge rst_ok_n) begin
		if (!rst_ok_n) begin
			if_gain <= 8'hFF;
			rf_gain <= 8'hFF;
		end else begin
			rf_gain <= total_gain[8] ? 8'hFF : total_gain[7:0];
			if_gain <= total_gain[8] ? total_gain[7:0] : 8'h00;
		end
	end

	// ----------------------------------------
	// Comb filter and path selection
	// ----------------------------------------
	reg [9:0] dline_q [0:11];
	genvar gi;
	generate
		for (gi = 0; gi < 12; gi = gi + 1) begin : g_dline
			always @(posedge core_clk or negedge rst_ok_n) begin
				if (!rst_ok_n)
					dline_q[gi] <= 10'h000;
				else if (sample_valid)
					dline_q[gi] <= (gi == 0) ? sample_in : dline_q[(gi == 0) ? 0 : gi - 1];
			end
		end
	endgenerate

	wire [10:0] x11 = {sample_in[9], sample_in};
	wire [10:0] d11 = {dline_q[11][9], dline_q[11]};
	wire [10:0] comb_out = x11 - d11;
	wire path_locked;
	// The comb costs about 3 dB on white noise, so it is used only when
	// it measurably wins.
	wire [10:0] sel_data = comb_sel ? comb_out : x11;

	always @(posedge core_clk or negedge rst_ok_n) begin
		if (!rst_ok_n) begin
			data_out <= 11'h000;
			data_valid <= 1'b0;
			comb_sel <= 1'b0;
			seg_lock <= 1'b0;
			seg_start <= 1'b0;
		end else begin
			data_valid <= sample_valid;
			if (sample_valid)
				data_out <= sel_data;
			comb_sel <= path_locked;
			seg_lock <= seg_locked;
			seg_start <= sample_valid && seg_locked && (pos_q == 10'h000);
		end
	end

	// ----------------------------------------
	// Stored field sync reference
	// ----------------------------------------
	reg [8:0] pn9_q;
	reg [5:0] pn6_q;
	reg [11:0] rhist_q;
	wire in_pn511 = (pos_q >= `PN511_START) && (pos_q < `PN63_A_START);
	wire in_mid = (pos_q >= `PN63_MID_START) && (pos_q < `PN63_C_START);
	wire in_fs = (pos_q < `CORR_END);
	wire pn63_restart = (pos_q == `PN63_A_START) || (pos_q == `PN63_MID_START) || (pos_q == `PN63_C_START);
	wire [5:0] pn6_now = pn63_restart ? PN63_SEED : pn6_q;
	wire [3:0] sync_pat = `SYNC_PATTERN;
	reg ref_bit;
	always @* begin
		if (pos_q < `PN511_START)
			ref_bit = sync_pat[~pos_q[1:0]];
		else if (in_pn511)
			ref_bit = pn9_q[8];
		else
			ref_bit = pn6_now[5];
	end
	wire ref_d12 = rhist_q[11];

	always @(posedge core_clk or negedge rst_ok_n) begin
		if (!rst_ok_n) begin
			pn9_q <= PN511_SEED;
			pn6_q <= PN63_SEED;
			rhist_q <= 12'h000;
		end else if (sample_valid) begin
			rhist_q <= {rhist_q[10:0], ref_bit};
			if (pos_q == `SEG_LEN_M1)
				pn9_q <= PN511_SEED;
			else if (in_pn511)
				pn9_q <= {pn9_q[7:0], ^(pn9_q & PN511_TAPS)};
			pn6_q <= {pn6_now[4:0], ^(pn6_now & PN63_TAPS)};
		end
	end

	// ----------------------------------------
	// Field sync correlation
	// ----------------------------------------
	// Symbol-spaced: the segment timing already says where each reference
	// symbol lands, so one product per symbol is enough.
	reg signed [21:0] base_acc_q;
	reg signed [21:0] mid_acc_q;
	reg [8:0] fseg_q;
	wire signed [21:0] dsx = {{11{sel_data[10]}}, sel_data};
	wire signed [21:0] dterm = ref_bit ? dsx : -dsx;
	wire signed [21:0] fterm = (comb_sel && ref_bit == ref_d12) ? 22'sh000000 : dterm;
	wire signed [21:0] corr_f1 = base_acc_q + mid_acc_q;
	wire signed [21:0] corr_f2 = base_acc_q - mid_acc_q;
	wire fs_hit = (corr_f1 > $signed(FS_THR)) || (corr_f2 > $signed(FS_THR));
	wire at_end = sample_valid && (pos_q == `CORR_END);
	wire fs_expect = (fseg_q == `FIELD_SEGS_M1);
	wire [FS_CONF_W-1:0] fs_count;
	wire fs_locked;
	// Field syncs come once in 313 segments, so after a first hit only the
	// predicted segment is judged; judging every one would undo each hit.
	wire fs_idle = (fs_count == {FS_CONF_W{1'b0}});

	always @(posedge core_clk or negedge rst_ok_n) begin
		if (!rst_ok_n) begin
			base_acc_q <= 22'sh000000;
			mid_acc_q <= 22'sh000000;
		end else if (sample_valid) begin
			if (pos_q == 10'h000) begin
				base_acc_q <= fterm;
				mid_acc_q <= 22'sh000000;
			end else if (in_mid)
				mid_acc_q <= mid_acc_q + fterm;
			else if (in_fs)
				base_acc_q <= base_acc_q + fterm;
		end
	end

	sync_confidence #(.W(FS_CONF_W), .THRESH(FS_CONF_THR)) u_fs_conf (
		.core_clk(core_clk),
		.rst_ok_n(rst_ok_n),
		.clear(!seg_locked),
		.tick(at_end && (fs_idle || fs_expect)),
		.hit(fs_hit),
		.count(fs_count),
		.locked(fs_locked)
	);

	always @(posedge core_clk or negedge rst_ok_n) begin
		if (!rst_ok_n) begin
			fseg_q <= 9'h000;
			field_sync <= 1'b0;
			field_id <= 1'b0;
			field_lock <= 1'b0;
		end else begin
			field_lock <= fs_locked && seg_locked;
			field_sync <= at_end && fs_locked && fs_expect;
			if (at_end) begin
				if ((fs_hit && fs_idle) || fs_expect)
					fseg_q <= 9'h000;
				else
					fseg_q <= fseg_q + 9'h001;
				if (fs_hit && (fs_expect || fs_idle))
					field_id <= mid_acc_q[21];
			end
		end
	end

	// ----------------------------------------
	// Interference-plus-noise measurement
	// ----------------------------------------
	reg [35:0] raw_acc_q;
	reg [35:0] comb_acc_q;
	reg [1:0] fs_avg_q;
	wire [9:0] rlvl = ref_bit ? `REF_LEVEL : (10'h000 - `REF_LEVEL);
	wire [9:0] rlvl12 = ref_d12 ? `REF_LEVEL : (10'h000 - `REF_LEVEL);
	wire [11:0] ref_comb = {{2{rlvl[9]}}, rlvl} - {{2{rlvl12[9]}}, rlvl12};
	wire signed [11:0] n_raw = sx - {{2{rlvl[9]}}, rlvl};
	wire signed [11:0] n_comb = {comb_out[10], comb_out} - ref_comb;
	wire signed [23:0] sq_raw = n_raw * n_raw;
	wire signed [23:0] sq_comb = n_comb * n_comb;
	wire meas_on = sample_valid && fs_locked && fs_expect && in_fs && (pos_q >= `COMB_DELAY);
	wire meas_done = at_end && fs_locked && fs_expect && (fs_avg_q == FS_AVG_M1);

	always @(posedge core_clk or negedge rst_ok_n) begin
		if (!rst_ok_n) begin
			raw_acc_q <= 36'h000000000;
			comb_acc_q <= 36'h000000000;
			fs_avg_q <= 2'h0;
		end else if (meas_done) begin
			raw_acc_q <= 36'h000000000;
			comb_acc_q <= 36'h000000000;
			fs_avg_q <= 2'h0;
		end else if (meas_on) begin
			raw_acc_q <= raw_acc_q + {12'h000, sq_raw};
			comb_acc_q <= comb_acc_q + {12'h000, sq_comb};
		end else if (at_end && fs_locked && fs_expect)
			fs_avg_q <= fs_avg_q + 2'h1;
	end

	sync_confidence #(.W(PATH_CONF_W), .THRESH(PATH_CONF_THR)) u_path_conf (
		.core_clk(core_clk),
		.rst_ok_n(rst_ok_n),
		.clear(!seg_locked),
		.tick(meas_done),
		.hit(comb_acc_q < raw_acc_q),
		.count(),
		.locked(path_locked)
	);

endmodule // vsb_sync_front

`default_nettype wire

// ===== dv/vsb_front_checker.sv
`timescale 1ns/1ps
`default_nettype none
module vsb_front_checker (
	input wire logic core_clk, // Block clock.
	input wire logic rst_n, // Reset, active low.
	input wire logic [9:0] sample_in, // Sample.
	input wire logic sample_valid, // Sample strobe.
	input wire logic [10:0] data_out, // Selected sample.
	input wire logic data_valid, // Output strobe.
	input wire logic comb_sel, // Comb path on.
	input wire logic seg_start, // Segment start.
	input wire logic seg_lock, // Segment lock.
	input wire logic field_sync, // Field sync pulse.
	input wire logic field_id, // Field number.
	input wire logic field_lock, // Field lock.
	input wire logic [7:0] if_gain, // IF gain.
	input wire logic [7:0] rf_gain, // RF gain.
	input wire logic [15:0] clk_ctrl // Clock steering.
);
	// ----
	// Checks
	// ----
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	logic [9:0] vcnt_q;
	logic seen_q;
	// Valids since the last segment start; armed only once a start was seen under lock.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			vcnt_q <= 10'h000;
			seen_q <= 1'b0;
		end else begin
			vcnt_q <= seg_start ? 10'h000 : vcnt_q + {9'h000, data_valid};
			seen_q <= seg_lock && (seen_q || seg_start);
		end
	end
	sequence s_take; sample_valid && !comb_sel; endsequence
	sequence s_give; data_valid && !comb_sel; endsequence
	property p_strobe; sample_valid |=> data_valid; endproperty
	a_strobe: assert property (p_strobe) else $error("output strobe missing");
	property p_lone; data_valid |-> $past(sample_valid); endproperty
	a_lone: assert property (p_lone) else $error("output strobe without sample");
	property p_raw; s_take ##1 s_give |-> data_out == {$past(sample_in[9]), $past(sample_in)}; endproperty
	a_raw: assert property (p_raw) else $error("bypass path sample wrong");
	property p_start; seg_start |-> seg_lock && $past(sample_valid); endproperty
	a_start: assert property (p_start) else $error("segment start while unlocked");
	property p_seglen; seg_start && seen_q |-> vcnt_q == 10'h33F; endproperty
	a_seglen: assert property (p_seglen) else $error("segment length wrong");
	property p_fsync; field_sync |-> field_lock ##1 !field_sync; endproperty
	a_fsync: assert property (p_fsync) else $error("field sync not a locked pulse");
	property p_fdep; field_lock |-> seg_lock; endproperty
	a_fdep: assert property (p_fdep) else $error("field lock without segment lock");
	property p_drop; $fell(seg_lock) |-> ##[0:2] !comb_sel; endproperty
	a_drop: assert property (p_drop) else $error("comb path kept after lock loss");
	property p_gain; rf_gain != 8'hFF |-> if_gain == 8'h00; endproperty
	a_gain: assert property (p_gain) else $error("RF cut before IF");
	property p_gstep; $changed({if_gain, rf_gain}) |-> $past(sample_valid, 2) || $past(sample_valid, 3); endproperty
	a_gstep: assert property (p_gstep) else $error("gain moved without a sample");
endmodule // vsb_front_checker
bind vsb_sync_front vsb_front_checker u_chk (.core_clk(core_clk), .rst_n(rst_n), .sample_in(sample_in),
	.sample_valid(sample_valid), .data_out(data_out), .data_valid(data_valid), .comb_sel(comb_sel),
	.seg_start(seg_start), .seg_lock(seg_lock), .field_sync(field_sync), .field_id(field_id),
	.field_lock(field_lock), .if_gain(if_gain), .rf_gain(rf_gain), .clk_ctrl(clk_ctrl));
`default_nettype wire

// ===== dv/adc_model.sv
`timescale 1ns/1ps
`default_nettype none
module adc_model (
	input wire logic core_clk, // Block clock.
	input wire logic [19:0] limit, // Emit until sent reaches this.
	input wire logic sync_on, // Insert segment sync.
	input wire logic [9:0] amp, // Sync level.
	input wire logic [1:0] ovl, // Bit 0 overload, bit 1 negative.
	input wire logic [1:0] fsf, // Field sync segment: 0 none, 1 first, 2 second field.
	output logic [9:0] sample_in, // Converter sample.
	output logic sample_valid, // One per symbol.
	output logic [19:0] sent // Samples emitted.
);
	// ----
	// Converter
	// ----
	logic [15:0] rnd_q;
	logic [19:0] pm;
	logic go;
	// The same training sequences the receiver keeps as its reference.
	localparam logic [8:0] PN9_SEED = 9'h1FF;
	localparam logic [8:0] PN9_TAPS = 9'h110;
	localparam logic [5:0] PN6_SEED = 6'h3F;
	localparam logic [5:0] PN6_TAPS = 6'h21;
	logic [8:0] pn9_q;
	logic [5:0] pn6_q;
	logic fbit;
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	initial begin
		rnd_q = 16'h0044;
		sample_in = 10'h000;
		sample_valid = 1'b0;
		sent = 20'h00000;
		pn9_q = PN9_SEED;
		pn6_q = PN6_SEED;
	end
	// Reference symbol of a field sync segment; the second field inverts the middle short run.
	always_comb begin
		if (pm < 20'd4)
			fbit = (pm == 20'd0) || (pm == 20'd3);
		else if (pm < 20'd515)
			fbit = pn9_q[8];
		else
			fbit = pn6_q[5] ^ (fsf == 2'h2 && pm >= 20'd578 && pm < 20'd641);
	end
	// Position in segment follows the count; symbol spacing is random.
	assign pm = sent % 20'd832;
	assign go = (sent != limit) && (rnd_q[1:0] != 2'h0);
	// Data levels stay small so four of them never mimic a sync; off the strobe the
	// line toggles, so a read between symbols is caught.
	always @(posedge core_clk) begin
		rnd_q <= lfsr(rnd_q);
		sample_valid <= go;
		if (!go)
			sample_in <= ~sample_in;
		else if (ovl[0])
			sample_in <= ovl[1] ? 10'h210 : 10'h1F0;
		else if (fsf != 2'h0 && pm < 20'd704)
			sample_in <= fbit ? amp : -amp;
		else if (sync_on && pm < 20'd4)
			sample_in <= (pm == 20'd0 || pm == 20'd3) ? amp : -amp;
		else
			sample_in <= {3'h0, rnd_q[4:2], 4'h0} - 10'h038;
		// The PN63 generator steps on every symbol, the PN511 one only in its run, field sync or not.
		if (go) begin
			sent <= sent + 20'h1;
			if (pm == 20'd831)
				pn9_q <= PN9_SEED;
			else if (pm >= 20'd4 && pm < 20'd515)
				pn9_q <= {pn9_q[7:0], ^(pn9_q & PN9_TAPS)};
			if (pm == 20'd514 || pm == 20'd577 || pm == 20'd640)
				pn6_q <= PN6_SEED;
			else
				pn6_q <= {pn6_q[4:0], ^(pn6_q & PN6_TAPS)};
		end
	end
endmodule // adc_model
`default_nettype wire

// ===== dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	// ----
	// Bench
	// ----
	logic core_clk, rst_n, sync_on, sample_valid, data_valid, comb_sel, seg_start;
	logic seg_lock, field_sync, field_id, field_lock;
	logic [19:0] limit, sent;
	logic [9:0] amp, sample_in;
	logic [1:0] ovl, fsf;
	logic [10:0] data_out;
	logic [7:0] if_gain, rf_gain;
	logic [15:0] clk_ctrl;
	integer failures, cmp_count, cyc, starts, s0, g0;
	adc_model u_adc (.core_clk(core_clk), .limit(limit), .sync_on(sync_on), .amp(amp), .ovl(ovl), .fsf(fsf),
		.sample_in(sample_in), .sample_valid(sample_valid), .sent(sent));
	vsb_sync_front DUT (.core_clk(core_clk), .rst_n(rst_n), .sample_in(sample_in),
		.sample_valid(sample_valid), .data_out(data_out), .data_valid(data_valid), .comb_sel(comb_sel),
		.seg_start(seg_start), .seg_lock(seg_lock), .field_sync(field_sync), .field_id(field_id),
		.field_lock(field_lock), .if_gain(if_gain), .rf_gain(rf_gain), .clk_ctrl(clk_ctrl));
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	task automatic chk_flag(input logic got, input logic exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// IF takes the top of the total gain; RF only moves once IF is empty.
	function automatic logic [15:0] gain_words(input integer g);
		gain_words = (g >= 256) ? {8'(g - 256), 8'hFF} : {8'h00, 8'(g)};
	endfunction
	function automatic integer gain_total(input logic [7:0] i, input logic [7:0] r);
		gain_total = (r == 8'hFF) ? 256 + i : r;
	endfunction
	// Let the converter emit n more symbols, then give the pipeline time to settle.
	task automatic run(input integer n);
		limit <= limit + n[19:0];
		@(posedge core_clk);
		while (sent != limit)
			@(posedge core_clk);
		repeat (6) @(posedge core_clk);
	endtask
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Hang guard; the whole run needs about 46000 cycles.
	always @(posedge core_clk) begin
		cyc++;
		if (seg_start === 1'b1)
			starts++;
		if (cyc == 90000) begin
			failures++;
			final_report;
		end
	end
	initial begin
		failures = 0;
		cmp_count = 0;
		cyc = 0;
		starts = 0;
		rst_n = 1'b0;
		limit = 20'h00000;
		sync_on = 1'b0;
		amp = 10'h050;
		ovl = 2'h1;
		fsf = 2'h0;
		repeat (6) @(posedge core_clk);
		chk_word({5'h00, data_out}, 16'h0000);
		chk_word({if_gain, rf_gain}, 16'hFFFF);
		chk_word(clk_ctrl, 16'h0000);
		chk_flag(seg_lock | field_lock | comb_sel | data_valid | field_sync | seg_start, 1'b0);
		rst_n <= 1'b1;
		repeat (4) @(posedge core_clk);
		$display("test reset done");
		// Overload lowers IF first, then RF; constant levels keep the correlator quiet.
		run(10);
		chk_word({if_gain, rf_gain}, gain_words(501));
		ovl <= 2'h3;
		run(290);
		chk_word({if_gain, rf_gain}, gain_words(211));
		$display("test overload done");
		// Clean syncs acquire lock; stop ten symbols into a segment.
		ovl <= 2'h0;
		sync_on <= 1'b1;
		run(10526);
		chk_flag(seg_lock, 1'b1);
		chk_word(clk_ctrl, 16'h0000);
		$display("test acquire done");
		// Sync 0x10 too high: sixteen hits each take 0x10 off the integrator.
		g0 = gain_total(if_gain, rf_gain);
		s0 = starts;
		amp <= 10'h060;
		run(13312);
		chk_word(16'(gain_total(if_gain, rf_gain)), 16'(g0 - 2));
		chk_word(16'(starts - s0), 16'h0010);
		chk_word(clk_ctrl, 16'h0000);
		$display("test coherent done");
		// One second-field sync segment: its sign is taken at once, but one hit is no lock.
		run(822);
		fsf <= 2'h2;
		run(832);
		fsf <= 2'h0;
		chk_flag(field_id, 1'b1);
		chk_flag(field_lock, 1'b0);
		$display("test field done");
		// Syncs vanish: lock holds through four misses and drops by ten.
		sync_on <= 1'b0;
		run(3328);
		chk_flag(seg_lock, 1'b1);
		run(4992);
		chk_flag(seg_lock, 1'b0);
		chk_flag(field_lock, 1'b0);
		chk_flag(comb_sel, 1'b0);
		$display("test loss done");
		final_report;
	end
endmodule // tb
`default_nettype wire
